// ### verilog/dnic_pkg.sv
// Shared constants and types for the day and night illumination controller.
package dnic_pkg;
   localparam int LIGHT_W = 16;
   localparam int DUTY_W = 8;
   localparam int CFG_W = 16;
   localparam int CFG_FLAG_HIGH_BIT = 6;
   localparam int CFG_FLAG_LOW_BIT = 5;
   localparam int CLK_MHZ = 125;
   localparam int MOVE_TIME_MS = 10;
   localparam int MOVE_CYCLES = MOVE_TIME_MS * 1000 * CLK_MHZ;
   localparam int PWM_PERIOD = 256;
   localparam logic [DUTY_W-1:0] RST_DUTY = 8'h80;

   typedef struct packed {
      logic [LIGHT_W-1:0] fullDim;
      logic [LIGHT_W-1:0] dimOff;
      logic [LIGHT_W-1:0] offClosed;
   } dnic_thr_t;

   typedef struct packed {
      logic a;
      logic b;
   } dnic_bridge_t;

   localparam dnic_bridge_t BRIDGE_IDLE = 2'h0;
   localparam dnic_bridge_t BRIDGE_OPEN = 2'h1;
   localparam dnic_bridge_t BRIDGE_CLOSE = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_CLEAR = 4'h4,
      ST_MOVE = 4'h8
   } dnic_state_t;

   typedef enum logic [3:0] {
      RG_FULL = 4'h1,
      RG_DIM = 4'h2,
      RG_OFF = 4'h4,
      RG_CLOSED = 4'h8
   } dnic_region_t;

   typedef enum logic [2:0] {
      LED_OFF = 3'h1,
      LED_FULL = 3'h2,
      LED_DIM = 3'h4
   } dnic_led_t;
endpackage

// ### verilog/dnic_pwm.sv
// Free-running PWM generator for the LED dimming current.
`timescale 1ns/1ps
module dnic_pwm
   import dnic_pkg::*;
#(
   parameter int PERIOD = PWM_PERIOD,
   parameter int DW = DUTY_W
)
(
   input wire logic clock,          // System clock.
   input wire logic rst_n,          // Synchronous reset, active low.
   input wire logic clkEn,          // Freezes all state while low.
   input wire logic run,            // Lets the output toggle.
   input wire logic [DW-1:0] duty,  // High cycles per period.
   output logic pwmOut              // Registered PWM level.
);
   localparam int CW = $clog2(PERIOD);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] count;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         count <= '0;
      else if (clkEn)
         count <= (count == LAST) ? '0 : count + 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         pwmOut <= 1'b0;
      else if (clkEn)
         pwmOut <= run && (CW'(duty) > count);
   end

   a_pwm_idle_low: assert property (@(posedge clock) disable iff (!rst_n)
      (clkEn && !run) |=> !pwmOut)
      else $error("PWM output high while not running");
endmodule

// ### verilog/dnic_controller.sv
// Day and night switching controller: filter bridge, LED driver and sensor handling.
// What this block does
// - With the mode button released when operation starts, the controller runs in interrupt mode.
// - With the mode button held when operation starts, the controller runs in automatic level mode.
// - In interrupt mode a sensor event is answered first by reading the sensor configuration register.
// - After a cleared dark-to-bright event the filter is closed and the LED driver disabled.
// - After a cleared bright-to-dark event the filter is opened and the LED driver enabled.
// - In automatic mode the dimming region keeps the filter open and drives the LED by PWM duty.
// - In automatic mode the LED-disabled region keeps the filter open and turns the LED off.
// - In automatic mode the filter-closed region closes the filter with the LED held off.
// - In automatic mode the sensor event line is ignored and only the light level decides.
`timescale 1ns/1ps
module dnic_controller
   import dnic_pkg::*;
#(
   parameter int MOVE_TICKS = MOVE_CYCLES,
   parameter int DW = DUTY_W
)
(
   input wire logic clock,                // System clock, 125 MHz.
   input wire logic rst_n,                // Synchronous reset, active low.
   input wire logic clkEn,                // Freezes all state while low.
   input wire logic modeSelectButton,     // High while the button is held down.
   input wire logic sensorEvent_n,        // Sensor event line, active low.
   input wire logic cfgReadAck,           // One-cycle pulse: configuration read done.
   input wire logic [CFG_W-1:0] cfgData,  // Configuration word, valid with cfgReadAck.
   input wire logic lightValid,           // One-cycle pulse: new light level.
   input wire logic [LIGHT_W-1:0] lightLevel, // Measured light level.
   input wire dnic_thr_t thresholds,      // Ascending region boundaries.
   input wire logic [DW-1:0] dimDuty,     // PWM duty for the dimming region.
   output logic cfgReadReq,               // Held high until cfgReadAck.
   output logic bridgeInputA,             // Filter motor bridge input A.
   output logic bridgeInputB,             // Filter motor bridge input B.
   output logic ledEnable,                // LED driver enabled.
   output logic ledPwm,                   // LED driver PWM level.
   output logic autoMode                  // High in automatic level mode.
);
   localparam logic [31:0] MOVE_LOAD = 32'(MOVE_TICKS);

   dnic_state_t state;
   dnic_region_t region;
   dnic_led_t ledMode;
   dnic_led_t next_ledMode;
   dnic_bridge_t bridge;
   logic started;
   logic filterClosed;
   logic next_filterClosed;
   logic applyNow;
   logic flagHigh;
   logic flagLow;
   logic pwmRaw;
   logic [31:0] moveCount;

   assign bridgeInputA = bridge.a;
   assign bridgeInputB = bridge.b;

   // The button is caught once, on the first enabled edge after reset.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         started <= 1'b0;
         autoMode <= 1'b0;
      end
      else if (clkEn && !started)
      begin
         started <= 1'b1;
         autoMode <= modeSelectButton;
      end
   end

   always_comb
   begin
      if (lightLevel < thresholds.fullDim)
         region = RG_FULL;
      else if (lightLevel < thresholds.dimOff)
         region = RG_DIM;
      else if (lightLevel < thresholds.offClosed)
         region = RG_OFF;
      else
         region = RG_CLOSED;
   end

   // Decide the new filter and LED targets for this cycle.
   always_comb
   begin
      applyNow = 1'b0;
      next_filterClosed = filterClosed;
      next_ledMode = ledMode;
      if (state == ST_IDLE && started && autoMode && lightValid)
      begin
         applyNow = 1'b1;
         unique case (region)
            RG_FULL:
            begin
               next_filterClosed = 1'b0;
               next_ledMode = LED_FULL;
            end
            RG_DIM:
            begin
               next_filterClosed = 1'b0;
               next_ledMode = LED_DIM;
            end
            RG_OFF:
            begin
               next_filterClosed = 1'b0;
               next_ledMode = LED_OFF;
            end
            RG_CLOSED:
            begin
               next_filterClosed = 1'b1;
               next_ledMode = LED_OFF;
            end
         endcase
      end
      else if (state == ST_CLEAR && sensorEvent_n)
      begin
         applyNow = 1'b1;
         if (flagHigh)
         begin
            next_filterClosed = 1'b1;
            next_ledMode = LED_OFF;
         end
         else if (flagLow)
         begin
            next_filterClosed = 1'b0;
            next_ledMode = LED_FULL;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state <= ST_IDLE;
      else if (clkEn)
      begin
         unique case (state)
            ST_IDLE:
               if (started && !autoMode && !sensorEvent_n)
                  state <= ST_READ;
               else if (applyNow && next_filterClosed != filterClosed)
                  state <= ST_MOVE;
            ST_READ:
               if (cfgReadAck)
                  state <= ST_CLEAR;
            ST_CLEAR:
               if (applyNow)
                  state <= (next_filterClosed != filterClosed) ? ST_MOVE : ST_IDLE;
            ST_MOVE:
               if (moveCount == 32'h1)
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cfgReadReq <= 1'b0;
      else if (clkEn)
      begin
         if (state == ST_IDLE && started && !autoMode && !sensorEvent_n)
            cfgReadReq <= 1'b1;
         else if (state == ST_READ && cfgReadAck)
            cfgReadReq <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         flagHigh <= 1'b0;
         flagLow <= 1'b0;
      end
      else if (clkEn && state == ST_READ && cfgReadAck)
      begin
         flagHigh <= cfgData[CFG_FLAG_HIGH_BIT];
         flagLow <= cfgData[CFG_FLAG_LOW_BIT];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         filterClosed <= 1'b0;
         ledMode <= LED_OFF;
      end
      else if (clkEn && applyNow)
      begin
         filterClosed <= next_filterClosed;
         ledMode <= next_ledMode;
      end
   end

   // The bridge drives only for the motor run time, then both inputs fall.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         bridge <= BRIDGE_IDLE;
         moveCount <= '0;
      end
      else if (clkEn)
      begin
         if (applyNow && next_filterClosed != filterClosed)
         begin
            bridge <= next_filterClosed ? BRIDGE_CLOSE : BRIDGE_OPEN;
            moveCount <= MOVE_LOAD;
         end
         else if (state == ST_MOVE && moveCount == 32'h1)
         begin
            bridge <= BRIDGE_IDLE;
            moveCount <= '0;
         end
         else if (state == ST_MOVE)
            moveCount <= moveCount - 32'h1;
      end
   end

   dnic_pwm #(
      .PERIOD(PWM_PERIOD),
      .DW(DW)
   ) u_pwm (
      .clock(clock),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .run(ledMode == LED_DIM),
      .duty(dimDuty),
      .pwmOut(pwmRaw)
   );

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ledEnable <= 1'b0;
         ledPwm <= 1'b0;
      end
      else if (clkEn)
      begin
         ledEnable <= (ledMode != LED_OFF);
         ledPwm <= (ledMode == LED_FULL) || (ledMode == LED_DIM && pwmRaw);
      end
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence clearHigh;
      state == ST_CLEAR && sensorEvent_n && flagHigh && clkEn ##1 clkEn[*2];
   endsequence
   sequence clearLow;
      state == ST_CLEAR && sensorEvent_n && !flagHigh && flagLow && clkEn ##1 clkEn[*2];
   endsequence
   // A sample may follow the next cycle, so the LED mode is checked where it is taken, the enable one cycle later.
   sequence autoSample(dnic_region_t r);
      state == ST_IDLE && started && autoMode && lightValid && region == r && clkEn ##1 clkEn;
   endsequence

   a_start_intr_mode: assert property ($rose(started) && !autoMode |-> !$past(modeSelectButton))
      else $error("Interrupt mode taken with button held");
   a_start_auto_mode: assert property ($rose(started) && autoMode |-> $past(modeSelectButton))
      else $error("Automatic mode taken with button released");
   a_event_read_first: assert property (state == ST_IDLE && started && !autoMode && !sensorEvent_n && clkEn
      |=> cfgReadReq && state == ST_READ)
      else $error("Event not answered by a configuration read");
   a_intr_act_after: assert property ($rose(bridge != BRIDGE_IDLE) && !autoMode |-> $past(state) == ST_CLEAR)
      else $error("Filter moved before the event was read and cleared");
   a_bright_closes: assert property (clearHigh |-> filterClosed && !ledEnable && !ledPwm)
      else $error("Bright event did not close filter and disable LED");
   a_dark_opens: assert property (clearLow |-> !filterClosed && ledEnable && ledPwm)
      else $error("Dark event did not open filter and enable LED");
   a_auto_dimming: assert property (autoSample(RG_DIM)
      |-> (!filterClosed && ledMode == LED_DIM) ##1 ledEnable)
      else $error("Dimming region not applied");
   a_auto_led_off: assert property (autoSample(RG_OFF)
      |-> (!filterClosed && ledMode == LED_OFF) ##1 !ledEnable)
      else $error("LED-disabled region not applied");
   a_auto_filter_close: assert property (autoSample(RG_CLOSED)
      |-> (filterClosed && ledMode == LED_OFF) ##1 !ledEnable)
      else $error("Filter-closed region not applied");
   a_auto_no_read: assert property (autoMode && started |-> !cfgReadReq && state != ST_READ)
      else $error("Sensor read issued in automatic mode");
   a_bridge_levels: assert property ((state == ST_MOVE) == (bridge == BRIDGE_OPEN || bridge == BRIDGE_CLOSE))
      else $error("Bridge inputs not complementary while moving or not idle otherwise");
   a_region_order: assert property (lightLevel >= thresholds.offClosed
      && thresholds.fullDim <= thresholds.dimOff && thresholds.dimOff <= thresholds.offClosed
      |-> region == RG_CLOSED)
      else $error("Region compare out of order");
endmodule

// ### tb/dnic_sensor_model.sv
// Behavioural light sensor that posts events and answers configuration reads.
`timescale 1ns/1ps
module dnic_sensor_model
   import dnic_pkg::*;
(
   input wire logic clock,              // System clock.
   input wire logic rst_n,              // Synchronous reset, active low.
   input wire logic raise,              // Bench asks for an event.
   input wire logic [CFG_W-1:0] flags,  // Word returned by the next read.
   input wire logic [3:0] delay,        // Wait before the read completes.
   input wire logic cfgReadReq,         // Read request from the controller.
   output logic sensorEvent_n,          // Event line, active low.
   output logic cfgReadAck,             // One-cycle read completion.
   output logic [CFG_W-1:0] cfgData     // Configuration word.
);
   logic [3:0] waitCnt;
   logic done;
   initial
   begin
      sensorEvent_n = 1'b1;
      cfgReadAck = 1'b0;
      cfgData = 16'h5a5a;
   end
   // Sampling on the rising edge keeps the bench's falling-edge writes of raise, flags and delay race free.
   always @(posedge clock)
   begin
      cfgReadAck <= 1'b0;
      // The word is only valid with the acknowledge, so it keeps changing otherwise.
      cfgData <= ~cfgData;
      if (!rst_n)
      begin
         sensorEvent_n <= 1'b1;
         waitCnt <= 4'h0;
         done <= 1'b0;
      end
      else if (raise)
         sensorEvent_n <= 1'b0;
      else if (!cfgReadReq)
      begin
         waitCnt <= 4'h0;
         done <= 1'b0;
      end
      else if (!done && waitCnt == delay)
      begin
         cfgReadAck <= 1'b1;
         cfgData <= flags;
         sensorEvent_n <= 1'b1;
         done <= 1'b1;
      end
      else if (!done)
         waitCnt <= waitCnt + 4'h1;
   end
endmodule

// ### tb/test_dnic_controller.sv
// Self-checking bench for the day and night controller against a reference model.
`timescale 1ns/1ps
module test_dnic_controller
   import dnic_pkg::*;
   ;
   localparam int TICKS = 8;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic modeSelectButton = 1'b0;
   logic clkEn = 1'b1;
   logic raise = 1'b0;
   logic [CFG_W-1:0] flags = 16'h0;
   logic [3:0] delay = 4'h0;
   logic lightValid = 1'b0;
   logic [LIGHT_W-1:0] lightLevel = 16'h0;
   dnic_thr_t thresholds = {16'h0100, 16'h0400, 16'h1000};
   logic [DUTY_W-1:0] dimDuty = 8'h40;
   logic sensorEvent_n, cfgReadAck, cfgReadReq, bridgeInputA, bridgeInputB, ledEnable, ledPwm, autoMode;
   logic [CFG_W-1:0] cfgData;
   logic reqPrev = 1'b0;
   dnic_bridge_t lastDrive = BRIDGE_IDLE;
   int moveCnt = 0, reqCnt = 0, cycles = 0, error_cnt = 0, n_tests = 0, seed = 23;
   int filterClosed = 0, ledExp = 0;
   int q[$];

   always #4 clock = ~clock;

   dnic_controller #(.MOVE_TICKS(TICKS)) dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .modeSelectButton(modeSelectButton), .sensorEvent_n(sensorEvent_n), .cfgReadAck(cfgReadAck),
      .cfgData(cfgData), .lightValid(lightValid), .lightLevel(lightLevel), .thresholds(thresholds),
      .dimDuty(dimDuty), .cfgReadReq(cfgReadReq), .bridgeInputA(bridgeInputA), .bridgeInputB(bridgeInputB),
      .ledEnable(ledEnable), .ledPwm(ledPwm), .autoMode(autoMode));

   dnic_sensor_model sensor_u (.clock(clock), .rst_n(rst_n), .raise(raise), .flags(flags), .delay(delay),
      .cfgReadReq(cfgReadReq), .sensorEvent_n(sensorEvent_n), .cfgReadAck(cfgReadAck), .cfgData(cfgData));

   // Counts driven bridge cycles and rising read requests as the controller shows them.
   always @(posedge clock)
   begin
      if (rst_n && {bridgeInputA, bridgeInputB} !== BRIDGE_IDLE)
      begin
         moveCnt++;
         lastDrive = {bridgeInputA, bridgeInputB};
      end
      if (cfgReadReq === 1'b1 && reqPrev !== 1'b1)
         reqCnt++;
      reqPrev = cfgReadReq;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         $display("ERROR timeout expected finished seen running");
         end_sim();
      end
   end

   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   // A move lasts exactly TICKS cycles with complementary inputs, and none when the position holds.
   task automatic check_bridge(input int closeNow);
      dnic_bridge_t want;
      int cnt;
      want = closeNow ? BRIDGE_CLOSE : BRIDGE_OPEN;
      cnt = (closeNow == filterClosed) ? 0 : TICKS;
      n_tests++;
      if (moveCnt != cnt || (cnt != 0 && lastDrive !== want))
      begin
         error_cnt++;
         $display("ERROR bridge expected %0d x %b seen %0d x %b", cnt, want, moveCnt, lastDrive);
      end
      filterClosed = closeNow;
   endtask

   // Counts LED high cycles over one PWM period; the enable must agree.
   task automatic check_led(input int exp);
      int highs;
      highs = 0;
      repeat (PWM_PERIOD)
      begin
         @(negedge clock);
         highs += (ledPwm === 1'b1);
      end
      n_tests++;
      if (highs != exp || ledEnable !== (exp != 0))
      begin
         error_cnt++;
         $display("ERROR led expected %0d seen %0d en %b", exp, highs, ledEnable);
      end
   endtask

   // With the clock enable low nothing may change: no sample is taken and the PWM phase stands.
   task automatic check_freeze();
      logic held;
      int changes;
      changes = 0;
      moveCnt = 0;
      clkEn = 1'b0;
      lightLevel = 16'hffff;
      lightValid = 1'b1;
      @(negedge clock);
      held = ledPwm;
      repeat (PWM_PERIOD)
      begin
         @(negedge clock);
         changes += (ledPwm !== held);
      end
      lightValid = 1'b0;
      clkEn = 1'b1;
      check_bit("frozen outputs", 1'b0, changes != 0 || moveCnt != 0);
   endtask

   task automatic do_reset(input logic btn);
      rst_n = 1'b0;
      modeSelectButton = btn;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      modeSelectButton = ~btn;
      filterClosed = 0;
      ledExp = 0;
      repeat (2) @(negedge clock);
      check_bit("autoMode", btn, autoMode);
   endtask

   task automatic event_cycle(input logic [CFG_W-1:0] f);
      int n;
      flags = f;
      delay = 4'($random(seed)) & 4'h7;
      moveCnt = 0;
      raise = 1'b1;
      @(negedge clock);
      raise = 1'b0;
      n = 0;
      while (cfgReadReq !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n++;
      end
      check_bit("idle before read", 1'b0, moveCnt != 0);
      repeat (40) @(negedge clock);
      if (f[CFG_FLAG_HIGH_BIT])
      begin
         check_bridge(1);
         ledExp = 0;
      end
      else if (f[CFG_FLAG_LOW_BIT])
      begin
         check_bridge(0);
         ledExp = PWM_PERIOD;
      end
      else
         check_bridge(filterClosed);
      check_led(ledExp);
   endtask

   task automatic sample(input logic [LIGHT_W-1:0] lvl);
      moveCnt = 0;
      lightLevel = lvl;
      lightValid = 1'b1;
      @(negedge clock);
      lightValid = 1'b0;
      lightLevel = ~lvl;
      repeat (14) @(negedge clock);
      check_bridge(lvl >= thresholds.offClosed);
      if (lvl < thresholds.fullDim)
         ledExp = PWM_PERIOD;
      else if (lvl < thresholds.dimOff)
         ledExp = dimDuty;
      else
         ledExp = 0;
      check_led(ledExp);
   endtask

   initial
   begin
      do_reset(1'b0);
      check_led(0);
      event_cycle(16'h0040);
      event_cycle(16'h0040);
      event_cycle(16'h0020);
      event_cycle(16'h0000);
      event_cycle(16'h0060);
      repeat (3) event_cycle(16'($random(seed)));
      check_bit("read count", 1'b1, reqCnt == 8);
      $display("test interrupt mode done");
      do_reset(1'b1);
      reqCnt = 0;
      dimDuty = 8'h01 | 8'($random(seed));
      raise = 1'b1;
      @(negedge clock);
      raise = 1'b0;
      q = '{16'h00ff, 16'h0100, 16'h03ff, 16'h0400, 16'h0fff, 16'h1000, 16'hffff, 16'h0fff, 16'h03ff, 16'h0000};
      repeat (5) q.push_back($random(seed) & 16'h1fff);
      foreach (q[i])
         sample(16'(q[i]));
      sample(16'h0100);
      check_freeze();
      check_bit("event ignored", 1'b0, reqCnt != 0);
      $display("test automatic mode done");
      end_sim();
   end
endmodule
